// >>> hw/cbsw_top.sv
// Bus cycle status, upper address, wait insertion and NMI edge capture
`timescale 1ns/10ps
module cbsw_top (
  // Clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // Core side: bus cycle request
  input  wire logic        i_cyc_start,
  input  wire logic [3:0]  i_cyc_code,
  input  wire logic [23:0] i_cyc_addr,
  input  wire logic        i_cyc_hi_lane,
  input  wire logic [3:0]  i_idle_code,
  // Core side: cycle progress and NMI
  output logic             o_cyc_busy,
  output logic             o_cyc_done,
  output logic             o_nmi_req,
  input  wire logic        i_nmi_clr,
  // System pins
  input  wire logic        i_nmi_n,
  input  wire logic        i_continuous_wait_in_n,
  input  wire logic [1:0]  i_wait_count_in_n,
  output logic [7:0]       o_upper_address_out,
  output logic             o_high_byte_lane_enable_n,
  output logic [3:0]       o_bus_cycle_status_code,
  output logic [1:0]       o_tstate_wait
);

  cbsw_pkg::cbsw_tstate_t st_r;
  cbsw_pkg::cbsw_tstate_t st_nxt;

  logic       nmi_lvl;
  logic       cw_lvl;
  logic [1:0] wc_lvl;
  logic       nmi_prev_r;
  logic [1:0] wcnt_r;
  logic [1:0] wcnt_nxt;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Each pin passes three stages; all reset to the inactive high level
  cbsw_sync #(.RST_VAL(1'b1)) u_sync_nmi (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_pin   (i_nmi_n),
    .o_level (nmi_lvl)
  );

  cbsw_sync #(.RST_VAL(1'b1)) u_sync_cw (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_pin   (i_continuous_wait_in_n),
    .o_level (cw_lvl)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_wsync
      cbsw_sync #(.RST_VAL(1'b1)) u_sync_wc (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_pin   (i_wait_count_in_n[gi]),
        .o_level (wc_lvl[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Wait count pins are active low; inverted value is the binary count
  wire [1:0] wait_count_val = ~wc_lvl;
  wire       continuous_wait_in_low      = ~cw_lvl;
  wire       nmi_fall       = nmi_prev_r & ~nmi_lvl;
  // Reserved idle code never leaves the pins; shown as inactive
  wire [3:0] idle_safe      = (i_idle_code == cbsw_pkg::CBSW_ST_RESERVED) ?
                              cbsw_pkg::CBSW_ST_INACTIVE : i_idle_code;
  wire       in_t2          = (st_r == cbsw_pkg::CBSW_T_2);
  wire       in_tw          = (st_r == cbsw_pkg::CBSW_T_WAIT);
  wire       cnt_left       = (wcnt_r != cbsw_pkg::CBSW_WCNT_ZERO);
  wire       hold_wait      = continuous_wait_in_low | cnt_left;
  // Upper address byte taken with the request; phase flags for the core
  wire [7:0] upper_sel      = i_cyc_addr[cbsw_pkg::CBSW_UPPER_LSB +:
                                         cbsw_pkg::CBSW_UPPER_W];
  wire [1:0] tstate_nxt     = {in_tw, in_t2};

  // ----------------------------------------------------------------
  // T-state sequencing: T1, T2, waits, T3
  // ----------------------------------------------------------------
  // The count pins are latched once, at the end of T1, since their
  // synchronisers lag by several cycles; count and continuous wait
  // overlap, so the longer of the two sets the number of waits
  always_comb begin
    st_nxt   = st_r;
    wcnt_nxt = wcnt_r;
    unique case (st_r)
      cbsw_pkg::CBSW_T_IDLE: begin
        if (i_cyc_start) begin
          st_nxt = cbsw_pkg::CBSW_T_1;
        end
      end
      cbsw_pkg::CBSW_T_1: begin
        st_nxt   = cbsw_pkg::CBSW_T_2;
        wcnt_nxt = wait_count_val;
      end
      cbsw_pkg::CBSW_T_2: begin
        if (continuous_wait_in_low || wcnt_r != cbsw_pkg::CBSW_WCNT_ZERO) begin
          st_nxt = cbsw_pkg::CBSW_T_WAIT;
          if (cnt_left) begin
            wcnt_nxt = wcnt_r - 2'h1;
          end
        end else begin
          st_nxt = cbsw_pkg::CBSW_T_3;
        end
      end
      cbsw_pkg::CBSW_T_WAIT: begin
        if (hold_wait) begin
          if (cnt_left) begin
            wcnt_nxt = wcnt_r - 2'h1;
          end
        end else begin
          st_nxt = cbsw_pkg::CBSW_T_3;
        end
      end
      cbsw_pkg::CBSW_T_3: begin
        st_nxt = cbsw_pkg::CBSW_T_IDLE;
      end
      default: begin
        st_nxt = cbsw_pkg::CBSW_T_IDLE;
      end
    endcase
  end

  // State and wait counter registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r   <= cbsw_pkg::CBSW_T_IDLE;
      wcnt_r <= cbsw_pkg::CBSW_WCNT_ZERO;
    end else if (i_ce) begin
      st_r   <= st_nxt;
      wcnt_r <= wcnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // NMI edge capture; edge sets over a same-cycle clear
  // ----------------------------------------------------------------
  // A held low level yields no second request: the pin must go high
  // and pass its synchroniser again before another edge is seen
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nmi_prev_r <= cbsw_pkg::CBSW_PIN_RST;
      o_nmi_req  <= 1'b0;
    end else if (i_ce) begin
      nmi_prev_r <= nmi_lvl;
      if (nmi_fall) begin
        o_nmi_req <= 1'b1;
      end else if (i_nmi_clr) begin
        o_nmi_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus outputs: status, upper address, high byte enable
  // ----------------------------------------------------------------
  wire st_start = (st_r == cbsw_pkg::CBSW_T_IDLE) & i_cyc_start;
  wire st_end   = (st_r == cbsw_pkg::CBSW_T_3);

  // The upper address is left standing between cycles; only the status
  // code and the byte enable return to their idle values
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus_cycle_status_code   <= cbsw_pkg::CBSW_STATUS_RST;
      o_upper_address_out       <= cbsw_pkg::CBSW_UPPER_RST;
      o_high_byte_lane_enable_n <= cbsw_pkg::CBSW_HBE_N_RST;
    end else if (i_ce) begin
      if (st_start) begin
        // Codes 4..7, 8..A, D..F pass through from the core
        o_bus_cycle_status_code   <= i_cyc_code;
        o_upper_address_out       <= upper_sel;
        o_high_byte_lane_enable_n <= ~i_cyc_hi_lane;
      end else if (st_r == cbsw_pkg::CBSW_T_IDLE || st_end) begin
        o_bus_cycle_status_code   <= idle_safe;
        o_high_byte_lane_enable_n <= 1'b1;
      end
    end
  end

  // Cycle progress flags for the core
  // A start held while busy is refused; busy follows the next state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cyc_busy    <= 1'b0;
      o_cyc_done    <= 1'b0;
      o_tstate_wait <= cbsw_pkg::CBSW_TW_RST;
    end else if (i_ce) begin
      o_cyc_busy    <= (st_nxt != cbsw_pkg::CBSW_T_IDLE);
      o_cyc_done    <= (st_nxt == cbsw_pkg::CBSW_T_3);
      o_tstate_wait <= tstate_nxt;
    end
  end

endmodule : cbsw_top

// >>> hw/cbsw_pkg.sv
// Package of constants and types for the bus status and wait block
package cbsw_pkg;

  // ----------------------------------------------------------------
  // Bus cycle status codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CBSW_ST_INACTIVE  = 4'h0;
  localparam logic [3:0] CBSW_ST_WAIT_INSN = 4'h1;
  localparam logic [3:0] CBSW_ST_RESERVED  = 4'h2;
  localparam logic [3:0] CBSW_ST_SLV_WAIT  = 4'h3;
  localparam logic [3:0] CBSW_ST_IACK_MST  = 4'h4;
  localparam logic [3:0] CBSW_ST_IACK_CAS  = 4'h5;
  localparam logic [3:0] CBSW_ST_EOI_MST   = 4'h6;
  localparam logic [3:0] CBSW_ST_EOI_CAS   = 4'h7;
  localparam logic [3:0] CBSW_ST_FETCH_SEQ = 4'h8;
  localparam logic [3:0] CBSW_ST_FETCH_NSQ = 4'h9;
  localparam logic [3:0] CBSW_ST_DATA      = 4'hA;
  localparam logic [3:0] CBSW_ST_SLV_OPND  = 4'hD;
  localparam logic [3:0] CBSW_ST_SLV_STAT  = 4'hE;
  localparam logic [3:0] CBSW_ST_SLV_ID    = 4'hF;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int         CBSW_ADDR_W      = 24;
  localparam int         CBSW_UPPER_LSB   = 16;
  localparam int         CBSW_UPPER_W     = 8;
  localparam logic [7:0] CBSW_UPPER_RST   = 8'h00;
  localparam logic [3:0] CBSW_STATUS_RST  = 4'h0;
  localparam logic [1:0] CBSW_WCNT_ZERO   = 2'h0;
  localparam logic [1:0] CBSW_SYNC_RST    = 2'h3;
  localparam logic       CBSW_PIN_RST     = 1'b1;
  localparam logic       CBSW_HBE_N_RST   = 1'b1;
  localparam logic [1:0] CBSW_TW_RST      = 2'h0;

  // Bus cycle phase (T-state) machine
  typedef enum logic [4:0] {
    CBSW_T_IDLE = 5'h01,
    CBSW_T_1    = 5'h02,
    CBSW_T_2    = 5'h04,
    CBSW_T_WAIT = 5'h08,
    CBSW_T_3    = 5'h10
  } cbsw_tstate_t;

endpackage : cbsw_pkg

// >>> hw/cbsw_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/10ps
module cbsw_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // Pin and filtered level
  input  wire logic i_pin,
  output logic      o_level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ----------------------------------------------------------------
  // Shift chain; level changes only when stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r    <= RST_VAL;
      s2_r    <= RST_VAL;
      s3_r    <= RST_VAL;
      o_level <= RST_VAL;
    end else if (i_ce) begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        o_level <= s3_r;
      end
    end
  end

endmodule : cbsw_sync

// >>> sim/cbsw_asserts.sv
// Checker of bus status, address, wait and NMI behaviour
`timescale 1ns/10ps
module cbsw_asserts (
  // Clock, reset and core side
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  input wire logic        i_cyc_start,
  input wire logic [3:0]  i_cyc_code,
  input wire logic [23:0] i_cyc_addr,
  input wire logic        i_cyc_hi_lane,
  input wire logic [3:0]  i_idle_code,
  input wire logic        o_cyc_busy,
  input wire logic        o_cyc_done,
  input wire logic        o_nmi_req,
  // System pins
  input wire logic        i_nmi_n,
  input wire logic        i_continuous_wait_in_n,
  input wire logic [7:0]  o_upper_address_out,
  input wire logic        o_high_byte_lane_enable_n,
  input wire logic [3:0]  o_bus_cycle_status_code
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Short views of a taken request and the pins
  wire logic       take = i_ce && i_cyc_start && !o_cyc_busy;
  wire logic [7:0] up   = i_cyc_addr[23:16];
  wire logic [3:0] st   = o_bus_cycle_status_code;
  wire logic       cw   = i_continuous_wait_in_n;
  a_code_taken:
    assert property (take |=> o_cyc_busy && st == $past(i_cyc_code))
    else $error("cycle code not shown");
  a_upper_addr:
    assert property (take |=> o_upper_address_out == $past(up))
    else $error("upper address wrong");
  a_hbe_lane:
    assert property (take |=> o_high_byte_lane_enable_n == !$past(i_cyc_hi_lane))
    else $error("high byte enable wrong");
  a_busy_code:
    assert property (o_cyc_busy |-> st[3] || st[2])
    else $error("idle code inside a cycle");
  a_idle_map:
    assert property (!o_cyc_busy && $stable(i_idle_code)
                     |-> st == ((i_idle_code == 4'h2) ? 4'h0 : i_idle_code))
    else $error("idle code wrong");
  a_status_stands:
    assert property (o_cyc_busy && $past(o_cyc_busy)
                     |-> $stable(st) && $stable(o_upper_address_out))
    else $error("status moved in a cycle");
  a_nmi_edge:
    assert property ($rose(o_nmi_req) |-> $past(i_nmi_n, 8))
    else $error("request without edge");
  a_continuous_wait_in_stall:
    assert property ($rose(o_cyc_done) |-> $past(cw, 3) || $past(cw, 4) || $past(cw, 5))
    else $error("done while stalled");
endmodule : cbsw_asserts

bind cbsw_top cbsw_asserts u_chk (.*);

// >>> sim/cbsw_partner.sv
// Wait generator model driving the wait pins
`timescale 1ns/10ps
module cbsw_partner (
  // Clock and wanted waits
  input  wire logic       i_clk,
  input  wire logic [1:0] i_count,
  input  wire logic       i_stall,
  input  wire logic       i_dma,
  // Wait pins, active low
  output logic            o_continuous_wait_in_n,
  output logic [1:0]      o_wcnt_n
);
  // Count pins idle in DMA cycles, which stall by continuous wait only
  always_ff @(posedge i_clk) begin
    o_wcnt_n  <= i_dma ? 2'h3 : ~i_count;
    o_continuous_wait_in_n <= ~i_stall;
  end
endmodule : cbsw_partner

// >>> sim/cbsw_top_tb.sv
// Self-checking bench of the bus status and wait block
`timescale 1ns/10ps
module cbsw_top_tb;
  logic        clk, continuous_wait_in_n, busy, done, req, hbe_n;
  logic        rst_n = 1'b0, start = 1'b0, hi = 1'b0, clr = 1'b0;
  logic        nmi_n = 1'b1, stall = 1'b0, dma = 1'b0, ce = 1'b1;
  logic [3:0]  code = 4'h0, idle = 4'h0, st;
  logic [1:0]  cnt = 2'h0, wcnt_n, tw;
  logic [23:0] addr = 24'h0;
  logic [7:0]  upper;
  int          err_count = 0, cmp_count = 0, cyc = 0;
  logic [3:0]  codes [10] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hD, 4'hE, 4'hF};
  cbsw_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_cyc_start(start),
    .i_cyc_code(code), .i_cyc_addr(addr), .i_cyc_hi_lane(hi), .i_idle_code(idle),
    .o_cyc_busy(busy), .o_cyc_done(done), .o_nmi_req(req), .i_nmi_clr(clr),
    .i_nmi_n(nmi_n), .i_continuous_wait_in_n(continuous_wait_in_n), .i_wait_count_in_n(wcnt_n),
    .o_upper_address_out(upper), .o_high_byte_lane_enable_n(hbe_n),
    .o_bus_cycle_status_code(st), .o_tstate_wait(tw));
  cbsw_partner u_far (.i_clk(clk), .i_count(cnt), .i_stall(stall), .i_dma(dma),
    .o_continuous_wait_in_n(continuous_wait_in_n), .o_wcnt_n(wcnt_n));
  // Clock and hang ceiling
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  // Compare and count
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : check
  // One bus cycle; n is edges from taking to done
  task automatic run(input logic [3:0] c, input logic [23:0] a, input logic h, output int n);
    int t2s = 0;
    int tws = 0;
    @(posedge clk);
    code  <= c;
    addr  <= a;
    hi    <= h;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    check("status", 24'(c), 24'(st));
    check("upper", 24'(a[23:16]), 24'(upper));
    check("hbe_n", 24'(!h), 24'(hbe_n));
    for (n = 1; done !== 1'b1 && n < 40; n++) begin
      @(posedge clk);
      #1;
      t2s += tw[0];
      tws += tw[1];
    end
    check("T2 flag", 24'h1, 24'(t2s));
    check("wait flags", 24'(n - 3), 24'(tws));
    @(posedge clk);
    #1;
    check("idle", 24'((idle == 4'h2) ? 4'h0 : idle), 24'(st));
  endtask : run
  // Idle codes, reserved one shown as inactive
  task automatic t_idle();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      idle <= 4'(k);
      repeat (2) @(posedge clk);
      #1;
      check("idle code", 24'((k == 2) ? 0 : k), 24'(st));
    end
  endtask : t_idle
  // Every cycle code with alternating lanes and addresses
  task automatic t_codes();
    int n;
    for (int i = 0; i < 10; i++) begin
      run(codes[i], {8'hC3 ^ 8'(i * 37), 16'h5AA5}, i[0], n);
      check("length", 24'h3, 24'(n));
    end
  endtask : t_codes
  // Counts 0..3, then count pins held idle in a DMA cycle
  task automatic t_count();
    int n;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      cnt <= (k == 4) ? 2'h3 : 2'(k);
      dma <= (k == 4);
      repeat (8) @(posedge clk);
      run(4'hA, 24'h80FF00, 1'b1, n);
      check("waits", (k == 4) ? 24'h3 : 24'(3 + k), 24'(n));
    end
  endtask : t_count
  // Continuous wait holds the cycle until released
  task automatic t_continuous_wait_in();
    int n;
    @(posedge clk);
    stall <= 1'b1;
    dma   <= 1'b0;
    cnt   <= 2'h0;
    repeat (6) @(posedge clk);
    fork
      run(4'h8, 24'h3C0000, 1'b0, n);
      begin
        repeat (12) @(posedge clk);
        stall <= 1'b0;
      end
    join
    check("stall", 24'h1, 24'(n > 12 && n < 26));
  endtask : t_continuous_wait_in
  // Falling edge sets the request; a held low level does not again
  task automatic t_nmi();
    @(posedge clk);
    nmi_n <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check("nmi set", 24'h1, 24'(req));
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    check("nmi level", 24'h0, 24'(req));
  endtask : t_nmi
  // Low enable freezes the block: a start given then is never taken
  task automatic t_ce();
    @(posedge clk);
    ce    <= 1'b0;
    code  <= 4'h9;
    start <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("frozen busy", 24'h0, 24'(busy));
    check("frozen status", 24'h3, 24'(st));
    @(posedge clk);
    ce    <= 1'b1;
    start <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("released busy", 24'h0, 24'(busy));
    check("released status", 24'h3, 24'(st));
  endtask : t_ce
  // Counts, then the verdict
  task automatic print_verdict();
    $display("compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  // Reset, then each scenario
  initial begin
    repeat (16) @(posedge clk);
    check("reset", 24'h20, 24'({st, upper, hbe_n, busy, done, req, tw}));
    rst_n <= 1'b1;
    t_idle();
    t_ce();
    t_codes();
    t_count();
    t_continuous_wait_in();
    t_nmi();
    print_verdict();
  end
endmodule : cbsw_top_tb
